// ==== verilog/ppil_pkg.sv ====
// constants and state layout of the parallel port line block
package ppil_pkg;
   localparam int NPORT = 6;
   localparam int PW    = 8;
   localparam int SELW  = 6;

   // byte offsets in the port register page
   localparam logic [7:0] OFS_P1_DATA = 8'h00;
   localparam logic [7:0] OFS_P1_DIR  = 8'h01;
   localparam logic [7:0] OFS_P2_DATA = 8'h02;
   localparam logic [7:0] OFS_P2_DIR  = 8'h03;
   localparam logic [7:0] OFS_P3_DATA = 8'h04;
   localparam logic [7:0] OFS_P3_DIR  = 8'h05;
   localparam logic [7:0] OFS_P4_DATA = 8'h06;
   localparam logic [7:0] OFS_SEL_MOD = 8'h08;
   localparam logic [7:0] OFS_SEL_DIR = 8'h09;
   localparam logic [7:0] OFS_SEL_DAT = 8'h0A;
   localparam logic [7:0] OFS_P6_DATA = 8'h0C;
   localparam logic [7:0] OFS_P6_DIR  = 8'h0D;
   localparam logic [7:0] OFS_P7_DATA = 8'h0E;
   localparam logic [7:0] OFS_P7_DIR  = 8'h0F;
   localparam logic [7:0] OFS_P7_MODE = 8'h10;
   localparam logic [7:0] OFS_P8_DATA = 8'h12;
   localparam logic [7:0] OFS_P8_DIR  = 8'h13;
   localparam logic [7:0] OFS_CTRL    = 8'h14;

   // control word bit positions, both low active
   localparam int CTRL_RW_MODE_BIT = 3;
   localparam int CTRL_BUS_EXT_BIT = 4;

   // reset values
   localparam logic [PW-1:0]   RST_DIR      = 8'hFF;
   localparam logic [PW-1:0]   RST_DATA     = 8'hFF;
   localparam logic [PW-1:0]   RST_P7_MODE  = 8'h00;
   localparam logic [SELW-1:0] RST_SEL_MODE = 6'h00;
   localparam logic [SELW-1:0] RST_SEL_DIR  = 6'h3F;
   localparam logic [SELW-1:0] RST_SEL_DATA = 6'h3F;
   localparam logic [PW-1:0]   RST_CTRL     = 8'hFF;

   // one clock is half an oscillator cycle
   localparam int HALF_PER_OSC     = 2;
   localparam int PD_BEFORE_OSC    = 2;
   localparam int PD_BEFORE_HALVES = PD_BEFORE_OSC * HALF_PER_OSC;
   localparam int CNTW             = 9;

   typedef struct packed {
      logic [NPORT-1:0][PW-1:0] dir;
      logic [NPORT-1:0][PW-1:0] dat;
      logic [NPORT-1:0][PW-1:0] pin_out;
      logic [NPORT-1:0][PW-1:0] pin_oe;
      logic [PW-1:0]            p7_mode;
      logic                     p4_dat;
      logic                     p4_is_out;
      logic                     p4_out;
      logic                     p4_oe;
      logic                     ext_rw;
      logic                     fetch_ext;
      logic [SELW-1:0]          sel_mode;
      logic [SELW-1:0]          sel_dir;
      logic [SELW-1:0]          sel_dat;
      logic [SELW-1:0]          sel_out;
      logic [SELW-1:0]          sel_oe;
      logic [PW-1:0]            ctrl;
      logic                     p8_last;
      logic                     req7;
      logic [CNTW-1:0]          cnt;
      logic                     cpu_phase_two_clock;
      logic                     pd;
      logic [PW-1:0]            rdata;
   } ppil_state_type;
endpackage : ppil_pkg

// ==== verilog/ppil_top.sv ====
// parallel port lines: ports 1-3, 6-8, single line port, select lines
// Contract
// - each line of ports 1-3 and 6-8 has its own direction bit
// - each of ports 1-3 and 6-8 owns one direction byte and one data byte
// - direction bit 0 turns the output driver on, 1 means input
// - reset sets every direction bit to 1, all lines inputs
// - ports 1-3 drive push-pull, ports 6-8 drive open drain
// - port reads return the pin level, also on output lines
// - falling edge on port 8 bit 7 requests source 7 unless priority 0
// - single line port is input after reset, first write makes it push-pull output
// - single line port reads return the pin level after it becomes output
// - control bit 3 active makes it the read/write line, driven only if CPU active
// - pin level during reset selects internal or external control word fetch
// - system bus mode removes general I/O from ports 1 to 4
// - select line mode bit 0 gives open drain I/O, 1 push-pull port select
// - select line direction bits reset to 1, writing 0 makes an output
// - select mode lines carry decoded read and write strobes of ports 1-3
// - port 7 mode bit 1 selects special mode; mode register resets to 0
// - port 7 special signals push-pull, port mode lines open drain
// - port 7 special: bit 7 power-down, bit 6 inverted rw, bits 5-0 bank
// - bank lines show the data register while A15 is 1, else 0
// - bit 6 special output is the inverse of CPU read/write
// - power-down low two oscillator cycles before phase two rise, half after
//
// Added by the designer: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ppil_top (
   input  wire logic                    CLK,
   input  wire logic                    RST_B,
   input  wire logic [7:0]              ADDR,
   input  wire logic [7:0]              WDATA,
   input  wire logic                    WR,
   input  wire logic                    RD,
   output logic      [7:0]              RDATA,
   input  wire logic [ppil_pkg::PW-1:0] P1_IN,
   output logic      [ppil_pkg::PW-1:0] P1_OUT,
   output logic      [ppil_pkg::PW-1:0] P1_OE,
   input  wire logic [ppil_pkg::PW-1:0] P2_IN,
   output logic      [ppil_pkg::PW-1:0] P2_OUT,
   output logic      [ppil_pkg::PW-1:0] P2_OE,
   input  wire logic [ppil_pkg::PW-1:0] P3_IN,
   output logic      [ppil_pkg::PW-1:0] P3_OUT,
   output logic      [ppil_pkg::PW-1:0] P3_OE,
   input  wire logic [ppil_pkg::PW-1:0] P6_IN,
   output logic      [ppil_pkg::PW-1:0] P6_OUT,
   output logic      [ppil_pkg::PW-1:0] P6_OE,
   input  wire logic [ppil_pkg::PW-1:0] P7_IN,
   output logic      [ppil_pkg::PW-1:0] P7_OUT,
   output logic      [ppil_pkg::PW-1:0] P7_OE,
   input  wire logic [ppil_pkg::PW-1:0] P8_IN,
   output logic      [ppil_pkg::PW-1:0] P8_OUT,
   output logic      [ppil_pkg::PW-1:0] P8_OE,
   input  wire logic                    SINGLE_LINE_PORT_IN,
   output logic                         SINGLE_LINE_PORT_OUT,
   output logic                         SINGLE_LINE_PORT_OE,
   input  wire logic [ppil_pkg::SELW-1:0] DUAL_FUNCTION_LINES_IN,
   output logic      [ppil_pkg::SELW-1:0] DUAL_FUNCTION_LINES_OUT,
   output logic      [ppil_pkg::SELW-1:0] DUAL_FUNCTION_LINES_OE,
   input  wire logic                    CPU_ACTIVE,
   input  wire logic                    CPU_RW,
   input  wire logic                    CPU_A15,
   input  wire logic [7:0]              OSC_DIVIDER,
   input  wire logic [2:0]              SRC7_PRIORITY,
   output logic                         SRC7_REQUEST,
   output logic                         EXT_RW_LEVEL,
   output logic                         FETCH_EXTERNAL,
   output logic                         CPU_PHASE_TWO_CLOCK
);
   import ppil_pkg::*;

   // port index order: 1, 2, 3, 6, 7, 8
   localparam logic [NPORT-1:0][7:0] DATA_OFS =
      {OFS_P8_DATA, OFS_P7_DATA, OFS_P6_DATA, OFS_P3_DATA, OFS_P2_DATA, OFS_P1_DATA};
   localparam logic [NPORT-1:0][7:0] DIR_OFS =
      {OFS_P8_DIR, OFS_P7_DIR, OFS_P6_DIR, OFS_P3_DIR, OFS_P2_DIR, OFS_P1_DIR};
   localparam int P7 = 4;

   ppil_state_type           st_ff;
   ppil_state_type           nxt_st;
   logic [NPORT-1:0][PW-1:0] pin_in;
   logic [CNTW-1:0]          period;
   logic [CNTW-1:0]          div_ext;
   logic [CNTW-1:0]          cnt_n;
   logic                     bus_ext;
   logic                     rw_mode;
   logic [PW-1:0]            p7_special;

   assign pin_in = {P8_IN, P7_IN, P6_IN, P3_IN, P2_IN, P1_IN};

   always_comb begin
      nxt_st = st_ff;
      bus_ext = ~st_ff.ctrl[CTRL_BUS_EXT_BIT];
      rw_mode = ~st_ff.ctrl[CTRL_RW_MODE_BIT];

      // register writes; outputs follow on the next edge, control word bits act one edge later
      if (WR) begin
         for (int k = 0; k < NPORT; k++) begin
            if (ADDR == DATA_OFS[k]) begin
               nxt_st.dat[k] = WDATA;
            end
            if (ADDR == DIR_OFS[k]) begin
               nxt_st.dir[k] = WDATA;
            end
         end
         unique case (ADDR)
            OFS_P4_DATA: begin
               nxt_st.p4_dat    = WDATA[0];
               nxt_st.p4_is_out = 1'b1;
            end
            OFS_SEL_MOD: nxt_st.sel_mode = WDATA[SELW-1:0];
            OFS_SEL_DIR: nxt_st.sel_dir  = WDATA[SELW-1:0];
            OFS_SEL_DAT: nxt_st.sel_dat  = WDATA[SELW-1:0];
            OFS_P7_MODE: nxt_st.p7_mode  = WDATA;
            OFS_CTRL:    nxt_st.ctrl     = WDATA;
            default: ;
         endcase
      end

      // read data stands for exactly one cycle
      nxt_st.rdata = 8'h00;
      if (RD) begin
         for (int k = 0; k < NPORT; k++) begin
            if (ADDR == DATA_OFS[k]) begin
               nxt_st.rdata = pin_in[k];
            end
            if (ADDR == DIR_OFS[k]) begin
               nxt_st.rdata = st_ff.dir[k];
            end
         end
         unique case (ADDR)
            OFS_P4_DATA: nxt_st.rdata = {7'h00, SINGLE_LINE_PORT_IN};
            OFS_SEL_MOD: nxt_st.rdata = {2'h0, st_ff.sel_mode};
            OFS_SEL_DIR: nxt_st.rdata = {2'h0, st_ff.sel_dir};
            OFS_SEL_DAT: nxt_st.rdata = {2'h0, DUAL_FUNCTION_LINES_IN};
            OFS_P7_MODE: nxt_st.rdata = st_ff.p7_mode;
            OFS_CTRL:    nxt_st.rdata = st_ff.ctrl;
            default: ;
         endcase
      end

      // phase two timing in half oscillator cycles, rise at count 0
      div_ext = {1'b0, OSC_DIVIDER};
      if (OSC_DIVIDER == 8'h00) begin
         div_ext = CNTW'(1);
      end
      period = CNTW'(div_ext << 1);
      cnt_n  = st_ff.cnt + CNTW'(1);
      if (cnt_n >= period) begin
         cnt_n = '0;
      end
      nxt_st.cnt  = cnt_n;
      nxt_st.cpu_phase_two_clock = cnt_n < div_ext;
      // at divider 2 or less the window covers the whole period: stays low
      nxt_st.pd = ~((cnt_n == '0) ||
                    (32'(cnt_n) + PD_BEFORE_HALVES >= 32'(period)));

      // port 7 special signals
      p7_special[7]   = nxt_st.pd;
      p7_special[6]   = ~CPU_RW;
      p7_special[5:0] = CPU_A15 ? st_ff.dat[P7][5:0] : 6'h00;

      // ports 1-3 push-pull, lost in system bus mode
      for (int k = 0; k < 3; k++) begin
         nxt_st.pin_out[k] = nxt_st.dat[k];
         nxt_st.pin_oe[k]  = bus_ext ? 8'h00 : ~nxt_st.dir[k];
      end
      // ports 6-8 open drain: pull low only
      for (int k = 3; k < NPORT; k++) begin
         nxt_st.pin_out[k] = 8'h00;
         nxt_st.pin_oe[k]  = ~nxt_st.dir[k] & ~nxt_st.dat[k];
      end
      // special lines need the direction set to output first
      for (int i = 0; i < PW; i++) begin
         if (nxt_st.p7_mode[i]) begin
            nxt_st.pin_out[P7][i] = p7_special[i];
            nxt_st.pin_oe[P7][i]  = ~nxt_st.dir[P7][i];
         end
      end

      // single line port
      nxt_st.p4_out = nxt_st.p4_dat;
      nxt_st.p4_oe  = nxt_st.p4_is_out && !bus_ext;
      if (rw_mode) begin
         nxt_st.p4_out = CPU_RW;
         nxt_st.p4_oe  = CPU_ACTIVE;
      end
      nxt_st.ext_rw = SINGLE_LINE_PORT_IN;

      // select lines: strobes of ports 1-3 or open drain I/O
      for (int j = 0; j < SELW; j++) begin
         if (nxt_st.sel_mode[j]) begin
            nxt_st.sel_out[j] = j[0] ? (WR && ADDR == DATA_OFS[j/2])
                                     : (RD && ADDR == DATA_OFS[j/2]);
            nxt_st.sel_oe[j]  = 1'b1;
         end else begin
            nxt_st.sel_out[j] = 1'b0;
            nxt_st.sel_oe[j]  = ~nxt_st.sel_dir[j] & ~nxt_st.sel_dat[j];
         end
      end

      // falling edge detect on port 8 bit 7
      nxt_st.p8_last = P8_IN[7];
      nxt_st.req7    = st_ff.p8_last && !P8_IN[7] && (SRC7_PRIORITY != 3'h0);
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         st_ff           <= '0;
         st_ff.dir       <= {NPORT{RST_DIR}};
         st_ff.dat       <= {NPORT{RST_DATA}};
         st_ff.p7_mode   <= RST_P7_MODE;
         st_ff.sel_mode  <= RST_SEL_MODE;
         st_ff.sel_dir   <= RST_SEL_DIR;
         st_ff.sel_dat   <= RST_SEL_DATA;
         st_ff.ctrl      <= RST_CTRL;
         st_ff.p8_last   <= 1'b1;
         st_ff.pd        <= 1'b1;
         // reset is synchronous, so the strap is simply sampled here
         st_ff.fetch_ext <= SINGLE_LINE_PORT_IN;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign RDATA                   = st_ff.rdata;
   assign P1_OUT                  = st_ff.pin_out[0];
   assign P1_OE                   = st_ff.pin_oe[0];
   assign P2_OUT                  = st_ff.pin_out[1];
   assign P2_OE                   = st_ff.pin_oe[1];
   assign P3_OUT                  = st_ff.pin_out[2];
   assign P3_OE                   = st_ff.pin_oe[2];
   assign P6_OUT                  = st_ff.pin_out[3];
   assign P6_OE                   = st_ff.pin_oe[3];
   assign P7_OUT                  = st_ff.pin_out[4];
   assign P7_OE                   = st_ff.pin_oe[4];
   assign P8_OUT                  = st_ff.pin_out[5];
   assign P8_OE                   = st_ff.pin_oe[5];
   assign SINGLE_LINE_PORT_OUT    = st_ff.p4_out;
   assign SINGLE_LINE_PORT_OE     = st_ff.p4_oe;
   assign DUAL_FUNCTION_LINES_OUT = st_ff.sel_out;
   assign DUAL_FUNCTION_LINES_OE  = st_ff.sel_oe;
   assign SRC7_REQUEST            = st_ff.req7;
   assign EXT_RW_LEVEL            = st_ff.ext_rw;
   assign FETCH_EXTERNAL          = st_ff.fetch_ext;
   assign CPU_PHASE_TWO_CLOCK     = st_ff.cpu_phase_two_clock;
endmodule : ppil_top
`default_nettype wire

// ==== test/ppil_assertions.sv ====
// concurrent checks on the port line block boundary
`timescale 1ns/1ps
`default_nettype none
module ppil_assertions (
   input wire logic       CLK,
   input wire logic       RST_B,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic       WR,
   input wire logic       RD,
   input wire logic [7:0] RDATA,
   input wire logic [7:0] P1_IN,
   input wire logic [7:0] P1_OUT,
   input wire logic [7:0] P1_OE,
   input wire logic [7:0] P6_OUT,
   input wire logic [7:0] P6_OE,
   input wire logic [7:0] P7_OUT,
   input wire logic [7:0] P7_OE,
   input wire logic [7:0] P8_IN,
   input wire logic [7:0] P8_OUT,
   input wire logic [7:0] P8_OE,
   input wire logic       SINGLE_LINE_PORT_OE,
   input wire logic [5:0] DUAL_FUNCTION_LINES_OUT,
   input wire logic [5:0] DUAL_FUNCTION_LINES_OE,
   input wire logic       CPU_A15,
   input wire logic [2:0] SRC7_PRIORITY,
   input wire logic [7:0] OSC_DIVIDER,
   input wire logic       SRC7_REQUEST,
   input wire logic       CPU_PHASE_TWO_CLOCK
);
   import ppil_pkg::*;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_B);
   chk_reset_off: assert property (disable iff (1'b0) !RST_B |=>
      (P1_OE | P6_OE | P7_OE | P8_OE) == 8'h00 && !SINGLE_LINE_PORT_OE)
      else $error("drivers enabled after reset");
   chk_p1_drive: assert property (WR && ADDR == OFS_P1_DATA |=> P1_OUT == $past(WDATA))
      else $error("port 1 drive value not updated by write");
   chk_open_drain: assert property (((P6_OE & P6_OUT) | (P8_OE & P8_OUT)) == 8'h00)
      else $error("open drain line driven high");
   chk_pin_read: assert property (RD && ADDR == OFS_P1_DATA |=> RDATA == $past(P1_IN))
      else $error("port read is not the pin level");
   chk_rdata_idle: assert property (!RD |=> RDATA == 8'h00)
      else $error("read data outside read answer");
   chk_src7_edge: assert property (SRC7_REQUEST == ($past(P8_IN[7], 2) &&
      !$past(P8_IN[7]) && $past(SRC7_PRIORITY) != 3'h0))
      else $error("source 7 request does not match falling edge");
   chk_bank_gate: assert property ((P7_OE[5:0] & P7_OUT[5:0]) != 6'h00 |-> $past(CPU_A15))
      else $error("bank lines high while A15 low");
   chk_sel_strobe: assert property (DUAL_FUNCTION_LINES_OE[1] &&
      DUAL_FUNCTION_LINES_OUT[1] |-> $past(WR) && $past(ADDR) == OFS_P1_DATA)
      else $error("select write strobe without port 1 write");
   // low time equals the divider in clocks, divider 0 running as 1, so each check is tied to one divider
   chk_phase_low: assert property ($fell(CPU_PHASE_TWO_CLOCK) && OSC_DIVIDER == 8'h04 |->
      !CPU_PHASE_TWO_CLOCK [*4] ##1 CPU_PHASE_TWO_CLOCK)
      else $error("phase two low time wrong");
   chk_phase_fast: assert property ($fell(CPU_PHASE_TWO_CLOCK) && OSC_DIVIDER == 8'h00 |->
      !CPU_PHASE_TWO_CLOCK ##1 CPU_PHASE_TWO_CLOCK)
      else $error("phase two low time wrong at divider zero");
   cov_src7: cover property (SRC7_REQUEST);
   cov_strobe: cover property (DUAL_FUNCTION_LINES_OE[1] && DUAL_FUNCTION_LINES_OUT[1]);
   cov_bank: cover property ((P7_OE[5:0] & P7_OUT[5:0]) != 6'h00);
endmodule : ppil_assertions
bind ppil_top ppil_assertions ppil_assertions_i (.CLK(CLK), .RST_B(RST_B), .ADDR(ADDR),
   .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .P1_IN(P1_IN), .P1_OUT(P1_OUT),
   .P1_OE(P1_OE), .P6_OUT(P6_OUT), .P6_OE(P6_OE), .P7_OUT(P7_OUT), .P7_OE(P7_OE),
   .P8_IN(P8_IN), .P8_OUT(P8_OUT), .P8_OE(P8_OE), .SINGLE_LINE_PORT_OE(SINGLE_LINE_PORT_OE),
   .DUAL_FUNCTION_LINES_OUT(DUAL_FUNCTION_LINES_OUT), .CPU_A15(CPU_A15),
   .DUAL_FUNCTION_LINES_OE(DUAL_FUNCTION_LINES_OE), .SRC7_PRIORITY(SRC7_PRIORITY),
   .SRC7_REQUEST(SRC7_REQUEST), .CPU_PHASE_TWO_CLOCK(CPU_PHASE_TWO_CLOCK),
   .OSC_DIVIDER(OSC_DIVIDER));
`default_nettype wire

// ==== test/ppil_pins.sv ====
// external pin model: enabled driver, else board level, plus a short to ground
`timescale 1ns/1ps
`default_nettype none
module ppil_pins #(
   parameter int W = 8
) (
   input  wire logic [W-1:0] oe,
   input  wire logic [W-1:0] out,
   input  wire logic [W-1:0] ext,
   input  wire logic [W-1:0] short_lo,
   output logic      [W-1:0] pin
);
   // a short always wins, so a driven high can still read back low
   assign pin = ((oe & out) | (~oe & ext)) & ~short_lo;
endmodule : ppil_pins
`default_nettype wire

// ==== test/testbench.sv ====
// self-checking bench for the parallel port lines
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import ppil_pkg::*;
   logic CLK = 1'b0, RST_B = 1'b0, WR = 1'b0, RD = 1'b0, CPU_A15 = 1'b0;
   logic CPU_ACTIVE = 1'b0, CPU_RW = 1'b1, sl_ext = 1'b0, sl_short = 1'b0;
   logic SRC7_REQUEST, EXT_RW_LEVEL, FETCH_EXTERNAL, CPU_PHASE_TWO_CLOCK;
   logic SINGLE_LINE_PORT_IN, SINGLE_LINE_PORT_OUT, SINGLE_LINE_PORT_OE;
   logic [2:0] SRC7_PRIORITY = 3'h1;
   logic [5:0] DUAL_FUNCTION_LINES_IN, DUAL_FUNCTION_LINES_OUT, DUAL_FUNCTION_LINES_OE;
   logic [7:0] ADDR = 8'h00, WDATA = 8'h00, OSC_DIVIDER = 8'h04, RDATA, cnt_pd, cnt_ph;
   logic [7:0] p1_short = 8'h80, p8_ext = 8'hFF, pp_ext = 8'h00, od_ext = 8'hFF, no_short = 8'h00;
   logic [5:0] dl_ext = 6'h3F, dl_short = 6'h00;
   logic [7:0] P1_IN, P1_OUT, P1_OE, P2_IN, P2_OUT, P2_OE, P3_IN, P3_OUT, P3_OE;
   logic [7:0] P6_IN, P6_OUT, P6_OE, P7_IN, P7_OUT, P7_OE, P8_IN, P8_OUT, P8_OE;
   logic [5:0][7:0] oe_a, out_a;
   int error_cnt = 0, samples_checked = 0;
   localparam logic [5:0][7:0] DIRS = {OFS_P8_DIR, OFS_P7_DIR, OFS_P6_DIR, OFS_P3_DIR,
      OFS_P2_DIR, OFS_P1_DIR};
   assign oe_a = {P8_OE, P7_OE, P6_OE, P3_OE, P2_OE, P1_OE};
   assign out_a = {P8_OUT, P7_OUT, P6_OUT, P3_OUT, P2_OUT, P1_OUT};
   ppil_top ppil_top_i (.*);
   // open drain ports see a pull-up, push-pull ports a low board level
   ppil_pins p1_pins (.oe(P1_OE), .out(P1_OUT), .ext(pp_ext), .short_lo(p1_short), .pin(P1_IN));
   ppil_pins p2_pins (.oe(P2_OE), .out(P2_OUT), .ext(pp_ext), .short_lo(no_short), .pin(P2_IN));
   ppil_pins p3_pins (.oe(P3_OE), .out(P3_OUT), .ext(pp_ext), .short_lo(no_short), .pin(P3_IN));
   ppil_pins p6_pins (.oe(P6_OE), .out(P6_OUT), .ext(od_ext), .short_lo(no_short), .pin(P6_IN));
   ppil_pins p7_pins (.oe(P7_OE), .out(P7_OUT), .ext(od_ext), .short_lo(no_short), .pin(P7_IN));
   ppil_pins p8_pins (.oe(P8_OE), .out(P8_OUT), .ext(p8_ext), .short_lo(no_short), .pin(P8_IN));
   ppil_pins #(.W(1)) sl_pins (.oe(SINGLE_LINE_PORT_OE), .out(SINGLE_LINE_PORT_OUT),
      .ext(sl_ext), .short_lo(sl_short), .pin(SINGLE_LINE_PORT_IN));
   ppil_pins #(.W(6)) dl_pins (.oe(DUAL_FUNCTION_LINES_OE), .out(DUAL_FUNCTION_LINES_OUT),
      .ext(dl_ext), .short_lo(dl_short), .pin(DUAL_FUNCTION_LINES_IN));
   always #2 CLK = ~CLK;
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1;
      chk(RDATA, exp);
   endtask : rd
   task automatic do_reset();
      @(posedge CLK);
      RST_B <= 1'b0;
      repeat (10) @(posedge CLK);
      RST_B <= 1'b1;
      #1;
      chk(P1_OE | P2_OE | P3_OE | P6_OE | P7_OE | P8_OE, 8'h00);
      chk({7'h00, SINGLE_LINE_PORT_OE}, 8'h00);
      chk({7'h00, FETCH_EXTERNAL}, {7'h00, sl_ext});
      rd(OFS_P7_MODE, 8'h00);
   endtask : do_reset
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : test_done
   initial begin
      repeat (3000) @(posedge CLK);
      error_cnt++;
      test_done();
   end
   initial begin
      do_reset();
      for (int i = 0; i < 6; i++) rd(DIRS[i], 8'hFF);
      rd(OFS_SEL_MOD, 8'h00);
      rd(OFS_SEL_DIR, 8'h3F);
      rd(8'h07, 8'h00);
      for (int i = 0; i < 6; i++) begin
         wr(DIRS[i], 8'h0F);
         wr(DIRS[i] - 8'h01, 8'hA5);
         chk(oe_a[i], (i < 3) ? 8'hF0 : 8'h50);
         chk(oe_a[i] & out_a[i], (i < 3) ? 8'hA0 : 8'h00);
         rd(DIRS[i] - 8'h01, (i == 0) ? 8'h20 : (i < 3) ? 8'hA0 : 8'hAF);
      end
      for (int p = 0; p < 2; p++) begin
         @(posedge CLK);
         SRC7_PRIORITY <= 3'(p);
         p8_ext <= 8'h7F;
         @(posedge CLK);
         #1;
         chk({7'h00, SRC7_REQUEST}, 8'(p));
         @(posedge CLK);
         p8_ext <= 8'hFF;
      end
      wr(OFS_P4_DATA, 8'h01);
      chk({SINGLE_LINE_PORT_OE, SINGLE_LINE_PORT_OUT, 6'h00}, 8'hC0);
      @(posedge CLK);
      sl_short <= 1'b1;
      CPU_ACTIVE <= 1'b1;
      CPU_RW <= 1'b0;
      rd(OFS_P4_DATA, 8'h00);
      wr(OFS_CTRL, 8'hF7);
      // control bits act on the drivers one edge after the write
      @(posedge CLK);
      #1;
      chk({SINGLE_LINE_PORT_OE, SINGLE_LINE_PORT_OUT, 6'h00}, 8'h80);
      @(posedge CLK);
      CPU_ACTIVE <= 1'b0;
      sl_short <= 1'b0;
      sl_ext <= 1'b1;
      rd(OFS_CTRL, 8'hF7);
      chk({7'h00, SINGLE_LINE_PORT_OE}, 8'h00);
      chk({7'h00, EXT_RW_LEVEL}, 8'h01);
      wr(OFS_CTRL, 8'hEF);
      @(posedge CLK);
      #1;
      chk(P1_OE | {7'h00, SINGLE_LINE_PORT_OE}, 8'h00);
      wr(OFS_CTRL, 8'hFF);
      wr(OFS_SEL_DIR, 8'h00);
      wr(OFS_SEL_DAT, 8'h2A);
      chk({2'h0, DUAL_FUNCTION_LINES_OE}, 8'h15);
      chk({2'h0, DUAL_FUNCTION_LINES_OUT & DUAL_FUNCTION_LINES_OE}, 8'h00);
      rd(OFS_SEL_DAT, 8'h2A);
      @(posedge CLK);
      dl_short <= 6'h02;
      rd(OFS_SEL_DAT, 8'h28);
      wr(OFS_SEL_MOD, 8'h3F);
      chk({2'h0, DUAL_FUNCTION_LINES_OE}, 8'h3F);
      for (int j = 0; j < 6; j++) begin
         if (j % 2 == 0)
            rd(8'(j), (j == 0) ? 8'h20 : 8'hA0);
         else
            wr(8'(j - 1), 8'hA5);
         chk({2'h0, DUAL_FUNCTION_LINES_OUT}, 8'(1 << j));
      end
      // direction first: special signals only drive once the line is an output
      wr(OFS_P7_DIR, 8'h00);
      wr(OFS_P7_DATA, 8'h15);
      @(posedge CLK);
      CPU_A15 <= 1'b1;
      CPU_RW <= 1'b1;
      wr(OFS_P7_MODE, 8'hFF);
      chk(P7_OE, 8'hFF);
      chk(P7_OUT & 8'h7F, 8'h15);
      @(posedge CLK);
      CPU_A15 <= 1'b0;
      CPU_RW <= 1'b0;
      @(posedge CLK);
      #1;
      chk(P7_OUT & 8'h7F, 8'h40);
      for (int d = 0; d < 2; d++) begin
         // second pass: divider 0 runs as 1, the power-down window covers the whole period
         if (d == 1) begin
            @(posedge CPU_PHASE_TWO_CLOCK);
            OSC_DIVIDER <= 8'h00;
         end
         cnt_pd = 8'h00;
         cnt_ph = 8'h00;
         repeat (8) begin
            @(posedge CLK);
            #1;
            cnt_pd += {7'h00, P7_OUT[7]};
            cnt_ph += {7'h00, CPU_PHASE_TWO_CLOCK};
         end
         chk(cnt_pd, (d == 0) ? 8'h03 : 8'h00);
         chk(cnt_ph, 8'h04);
      end
      @(posedge CLK);
      sl_ext <= 1'b1;
      do_reset();
      test_done();
   end
endmodule : testbench
`default_nettype wire
